//--- adcrc_axil.v
// AXI4-Lite slave front end: takes one write and one read at a time,
// hands writes on as a pulse and answers reads from three words.
// Assumes the master holds valid and payload until each handshake.
`timescale 1ns/100ps
`default_nettype none
`include "adcrc_map.vh"

module adcrc_axil (
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] ctrl_word,
  input wire [31:0] stat_word,
  input wire [31:0] done_word,
  output wire ctrl_wr,
  output wire [31:0] wr_data,
  output wire [3:0] wr_strb
);

  wire wr_take;
  wire rd_take;
  wire wr_mapped;
  wire rd_mapped;

  // Both write channels are taken in the same edge
  assign wr_take = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign wr_mapped = (s_axi_awaddr[7:2] <= `ADCRC_OFS_DONE >> 2);
  assign rd_mapped = (s_axi_araddr[7:2] <= `ADCRC_OFS_DONE >> 2);
  // Only the control word is writable; the others ignore writes
  assign ctrl_wr = wr_take & (s_axi_awaddr[7:2] == `ADCRC_OFS_CTRL >> 2);
  assign wr_data = s_axi_wdata;
  assign wr_strb = s_axi_wstrb;

  ////////////////////////////////////////////////////////////////////
  // Write path: ready one cycle after both valids, response after
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADCRC_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `ADCRC_RESP_OKAY : `ADCRC_RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path: data captured at the address handshake
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ADCRC_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_mapped ? `ADCRC_RESP_OKAY : `ADCRC_RESP_DECERR;
        case (s_axi_araddr[7:2])
          `ADCRC_OFS_CTRL >> 2: s_axi_rdata <= ctrl_word;
          `ADCRC_OFS_STAT >> 2: s_axi_rdata <= stat_word;
          `ADCRC_OFS_DONE >> 2: s_axi_rdata <= done_word;
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

//--- adcrc_dcnt.v
// Loadable down counter that pulses once when it runs out.
// Assumes load and load value come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none

module adcrc_dcnt #(
  parameter W = 16
) (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [W-1:0] load_val,
  input wire abort,
  output reg expire_ff
);

  reg [W-1:0] cnt_ff;

  ////////////////////////////////////////////////////////////////////
  // Count down to zero, pulse on the last step
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= {W{1'b0}};
      expire_ff <= 1'b0;
    end else begin
      expire_ff <= 1'b0;
      if (abort) begin
        cnt_ff <= {W{1'b0}};
      end else if (load) begin
        cnt_ff <= load_val;
      end else if (cnt_ff != {W{1'b0}}) begin
        cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
        expire_ff <= (cnt_ff == {{(W-1){1'b0}}, 1'b1}); // Last step
      end
    end
  end

endmodule
`default_nettype wire

//--- adcrc_map.vh
// Constants for the conversion run control block: register map,
// field positions, reset values, start latencies and timing figures.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef ADCRC_MAP_VH
`define ADCRC_MAP_VH

// Byte offsets on the register bus
`define ADCRC_OFS_CTRL 8'h00
`define ADCRC_OFS_STAT 8'h04
`define ADCRC_OFS_DONE 8'h08

// Control word fields
`define ADCRC_B_RUN 0
`define ADCRC_B_CMP 1
`define ADCRC_B_SCAN 2
`define ADCRC_B_ONESHOT 3
`define ADCRC_B_TRIG_LO 4
`define ADCRC_B_TRIG_HI 5
`define ADCRC_B_DIV_LO 8
`define ADCRC_B_DIV_HI 10
`define ADCRC_CTRL_RST 32'h0000_0000

// Status word fields
`define ADCRC_B_STATE_LO 0
`define ADCRC_B_STATE_HI 3
`define ADCRC_B_CHAN_LO 4
`define ADCRC_B_CHAN_HI 5
`define ADCRC_B_UNSETTLED 6

// Trigger modes
`define ADCRC_TRIG_SW 2'h0
`define ADCRC_TRIG_NOWAIT 2'h1
`define ADCRC_TRIG_WAIT 2'h2

// Start latency in system clocks per divider code, and in wait mode
`define ADCRC_LAT_0 16'd63
`define ADCRC_LAT_1 16'd31
`define ADCRC_LAT_2 16'd15
`define ADCRC_LAT_3 16'd7
`define ADCRC_LAT_4 16'd5
`define ADCRC_LAT_5 16'd4
`define ADCRC_LAT_6 16'd3
`define ADCRC_LAT_7 16'd1
`define ADCRC_LAT_WAIT 16'd1

// Conversion clock divisors per divider code
`define ADCRC_DIV_0 16'd64
`define ADCRC_DIV_1 16'd32
`define ADCRC_DIV_2 16'd16
`define ADCRC_DIV_3 16'd8
`define ADCRC_DIV_4 16'd6
`define ADCRC_DIV_5 16'd5
`define ADCRC_DIV_6 16'd4
`define ADCRC_DIV_7 16'd2

// Comparator settling time and system clock rate
`define ADCRC_SETTLE_NS 1000
`define ADCRC_CLK_MHZ 40
`define ADCRC_SETTLE_CYC ((`ADCRC_SETTLE_NS * `ADCRC_CLK_MHZ + 999) / 1000)
`define ADCRC_RESP_OKAY 2'h0
`define ADCRC_RESP_DECERR 2'h3

`endif

//--- adcrc_top.v
// Run/stop control of a successive-approximation converter: run bit,
// comparator enable, trigger modes, start latency and scan sequencing.
// Assumes software on AXI4-Lite and a one-cycle trigger pulse, both
// synchronous to clk.
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "adcrc_map.vh"

module adcrc_top #(
  parameter CONV_FAD = 16'd19,
  parameter STAB_CYC = 16'd40
) (
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire hw_trig,
  output reg conv_run_bit_ff,
  output reg comparator_enable_bit_ff,
  output reg conv_busy_ff,
  output reg conv_done_ff,
  output reg [1:0] conv_chan_ff
);

  // One-hot sequencer states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_STAB = 4'b0010;
  localparam [3:0] ST_LAT = 4'b0100;
  localparam [3:0] ST_CONV = 4'b1000;
  localparam [31:0] SETTLE_W = `ADCRC_SETTLE_CYC;
  localparam [15:0] SETTLE_CYC = SETTLE_W[15:0];

  reg scan_ff;
  reg oneshot_ff;
  reg [1:0] trig_ff;
  reg [2:0] clock_divider_sel_ff;
  reg [3:0] state_ff;
  reg unsettled_ff;
  reg [15:0] settle_cnt_ff;
  reg [15:0] done_cnt_ff;
  reg nxt_run;
  reg nxt_cmp;
  reg nxt_scan;
  reg nxt_oneshot;
  reg [1:0] nxt_trig;
  reg [2:0] nxt_div;
  reg [3:0] nxt_state;
  reg [1:0] nxt_chan;
  reg nxt_unsettled;
  reg nxt_done;
  reg lat_load;
  reg [15:0] lat_val;
  reg conv_load;
  reg halt;
  reg [15:0] start_lat;
  reg [15:0] fad_div;

  wire ctrl_wr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire lat_expire;
  wire conv_expire;
  wire wr_run0;
  wire wr_run1;
  wire [1:0] wr_trig;
  wire wr_cmp;
  wire is_wait;
  wire is_nowait;
  wire group_end;
  wire [15:0] conv_cyc;
  wire [31:0] ctrl_word;
  wire [31:0] stat_word;
  wire [31:0] done_word;

  ////////////////////////////////////////////////////////////////////
  // Bus slave and the two timers
  adcrc_axil u_axil (
    .clk(clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .ctrl_word(ctrl_word),
    .stat_word(stat_word),
    .done_word(done_word),
    .ctrl_wr(ctrl_wr),
    .wr_data(wr_data),
    .wr_strb(wr_strb)
  );

  // Stabilization wait and start latency share one timer
  adcrc_dcnt #(.W(16)) u_lat_tmr (
    .clk(clk),
    .rst(rst),
    .load(lat_load),
    .load_val(lat_val),
    .abort(halt),
    .expire_ff(lat_expire)
  );

  adcrc_dcnt #(.W(16)) u_conv_tmr (
    .clk(clk),
    .rst(rst),
    .load(conv_load),
    .load_val(conv_cyc),
    .abort(halt),
    .expire_ff(conv_expire)
  );

  ////////////////////////////////////////////////////////////////////
  // Divider code to start latency and conversion clock divisor
  always @* begin
    case (clock_divider_sel_ff)
      3'h0: begin start_lat = `ADCRC_LAT_0; fad_div = `ADCRC_DIV_0; end
      3'h1: begin start_lat = `ADCRC_LAT_1; fad_div = `ADCRC_DIV_1; end
      3'h2: begin start_lat = `ADCRC_LAT_2; fad_div = `ADCRC_DIV_2; end
      3'h3: begin start_lat = `ADCRC_LAT_3; fad_div = `ADCRC_DIV_3; end
      3'h4: begin start_lat = `ADCRC_LAT_4; fad_div = `ADCRC_DIV_4; end
      3'h5: begin start_lat = `ADCRC_LAT_5; fad_div = `ADCRC_DIV_5; end
      3'h6: begin start_lat = `ADCRC_LAT_6; fad_div = `ADCRC_DIV_6; end
      default: begin start_lat = `ADCRC_LAT_7; fad_div = `ADCRC_DIV_7; end
    endcase
  end

  // Product fits: 19 x 64 is far below 16 bits
  assign conv_cyc = CONV_FAD * fad_div;

  // Decoded software writes to the run bit and mode fields
  assign wr_run0 = ctrl_wr & wr_strb[0] & ~wr_data[`ADCRC_B_RUN];
  assign wr_run1 = ctrl_wr & wr_strb[0] & wr_data[`ADCRC_B_RUN];
  assign wr_trig = wr_data[`ADCRC_B_TRIG_HI:`ADCRC_B_TRIG_LO];
  assign wr_cmp = wr_data[`ADCRC_B_CMP];
  assign is_wait = (trig_ff == `ADCRC_TRIG_WAIT);
  assign is_nowait = (trig_ff == `ADCRC_TRIG_NOWAIT);
  assign group_end = ~scan_ff | (conv_chan_ff == 2'h3);

  ////////////////////////////////////////////////////////////////////
  // Next-state logic of run bit, configuration and sequencer
  always @* begin
    nxt_run = conv_run_bit_ff;
    nxt_cmp = comparator_enable_bit_ff;
    nxt_scan = scan_ff;
    nxt_oneshot = oneshot_ff;
    nxt_trig = trig_ff;
    nxt_div = clock_divider_sel_ff;
    nxt_state = state_ff;
    nxt_chan = conv_chan_ff;
    nxt_unsettled = unsettled_ff;
    nxt_done = 1'b0;
    lat_load = 1'b0;
    lat_val = start_lat;
    conv_load = 1'b0;
    halt = 1'b0;
    // Field writes; mode changes mid-run are software's hazard
    if (ctrl_wr && wr_strb[0]) begin
      nxt_cmp = wr_cmp;
      nxt_scan = wr_data[`ADCRC_B_SCAN];
      nxt_oneshot = wr_data[`ADCRC_B_ONESHOT];
      nxt_trig = wr_trig;
    end
    if (ctrl_wr && wr_strb[1]) begin
      nxt_div = wr_data[`ADCRC_B_DIV_HI:`ADCRC_B_DIV_LO];
    end
    // Sequencer walk
    case (state_ff)
      ST_IDLE: begin
        if (conv_run_bit_ff && is_nowait && hw_trig && comparator_enable_bit_ff) begin
          nxt_state = ST_LAT;
          nxt_chan = 2'h0;
          lat_load = 1'b1;
        end
      end
      ST_STAB: begin
        if (lat_expire) begin
          nxt_state = ST_LAT;
          lat_load = 1'b1;
          lat_val = `ADCRC_LAT_WAIT;
        end
      end
      ST_LAT: begin
        if (lat_expire) begin
          nxt_state = ST_CONV;
          conv_load = 1'b1;
        end
      end
      ST_CONV: begin
        if (conv_expire) begin
          nxt_done = 1'b1;
          if (!group_end) begin
            nxt_chan = conv_chan_ff + 2'h1;
            conv_load = 1'b1;
          end else if (!oneshot_ff) begin
            nxt_chan = 2'h0;
            conv_load = 1'b1;
          end else if (is_nowait) begin
            nxt_chan = 2'h0;
            nxt_state = ST_IDLE;
          end else begin
            nxt_chan = 2'h0;
            nxt_state = ST_IDLE;
            nxt_run = 1'b0;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Write of 0 stops or returns to standby in every mode, except against a same-cycle trigger in wait mode
    if (wr_run0) begin
      nxt_run = 1'b0;
      nxt_state = ST_IDLE;
      nxt_chan = 2'h0;
      halt = 1'b1;
      lat_load = 1'b0;
      conv_load = 1'b0;
    end
    // Write of 1 honoured only when stopped; ignored in wait mode
    if (wr_run1 && !conv_run_bit_ff && wr_cmp && wr_trig != `ADCRC_TRIG_WAIT) begin
      nxt_run = 1'b1;
      nxt_chan = 2'h0;
      // Too early after comparator enable: first result is suspect
      nxt_unsettled = (settle_cnt_ff < SETTLE_CYC);
      if (wr_trig == `ADCRC_TRIG_SW) begin
        nxt_state = ST_LAT;
        lat_load = 1'b1;
        lat_val = start_lat;
      end
    end
    // Trigger in wait mode beats a same-cycle clear of the run bit
    if (is_wait && hw_trig && comparator_enable_bit_ff &&
        (state_ff == ST_IDLE || wr_run0)) begin
      nxt_run = 1'b1;
      nxt_state = ST_STAB;
      nxt_chan = 2'h0;
      halt = 1'b0;
      lat_load = 1'b1;
      lat_val = STAB_CYC[15:0];
      nxt_unsettled = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State and control registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_run_bit_ff <= 1'b0;
      comparator_enable_bit_ff <= 1'b0;
      scan_ff <= 1'b0;
      oneshot_ff <= 1'b0;
      trig_ff <= `ADCRC_TRIG_SW;
      clock_divider_sel_ff <= 3'h0;
      state_ff <= ST_IDLE;
      conv_chan_ff <= 2'h0;
      unsettled_ff <= 1'b0;
      conv_done_ff <= 1'b0;
      conv_busy_ff <= 1'b0;
    end else begin
      conv_run_bit_ff <= nxt_run;
      comparator_enable_bit_ff <= nxt_cmp;
      scan_ff <= nxt_scan;
      oneshot_ff <= nxt_oneshot;
      trig_ff <= nxt_trig;
      clock_divider_sel_ff <= nxt_div;
      state_ff <= nxt_state;
      conv_chan_ff <= nxt_chan;
      unsettled_ff <= nxt_unsettled;
      conv_done_ff <= nxt_done;
      conv_busy_ff <= (nxt_state == ST_CONV);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Comparator settling counter, saturating; restarts when disabled
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_cnt_ff <= 16'h0000;
    end else if (!comparator_enable_bit_ff) begin
      settle_cnt_ff <= 16'h0000;
    end else if (settle_cnt_ff < SETTLE_CYC) begin
      settle_cnt_ff <= settle_cnt_ff + 16'h0001;
    end
  end

  // Count of finished conversions, wraps
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      done_cnt_ff <= 16'h0000;
    end else if (nxt_done) begin
      done_cnt_ff <= done_cnt_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read-back words
  assign ctrl_word = {21'h000000, clock_divider_sel_ff, 2'h0, trig_ff,
                      oneshot_ff, scan_ff, comparator_enable_bit_ff,
                      conv_run_bit_ff};
  assign stat_word = {25'h0000000, unsettled_ff, conv_chan_ff, state_ff};
  assign done_word = {16'h0000, done_cnt_ff};

endmodule
`default_nettype wire

//--- adcrc_top_props.sv
// Checker for the run control block, seeing only its top ports.
// Assumes write address and data are taken at the same edge.
`timescale 1ns/100ps
`default_nettype none
`include "adcrc_map.vh"

module adcrc_top_props #(
  parameter CONV_FAD = 16'd19,
  parameter STAB_CYC = 16'd40
) (
  input wire clk, input wire rst,
  input wire [7:0] s_axi_awaddr, input wire s_axi_awvalid, input wire s_axi_awready,
  input wire [31:0] s_axi_wdata, input wire [3:0] s_axi_wstrb, input wire s_axi_wvalid,
  input wire s_axi_wready, input wire [1:0] s_axi_bresp, input wire s_axi_bvalid,
  input wire s_axi_bready, input wire [7:0] s_axi_araddr, input wire s_axi_arvalid,
  input wire s_axi_arready, input wire [31:0] s_axi_rdata, input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid, input wire s_axi_rready, input wire hw_trig,
  input wire conv_run_bit_ff, input wire comparator_enable_bit_ff,
  input wire conv_busy_ff, input wire conv_done_ff, input wire [1:0] conv_chan_ff
);
  reg [1:0] trig_ff;
  reg scan_ff;
  reg shot_ff;
  reg [2:0] div_ff;
  wire wr_hs;
  wire [1:0] wr_trig;

  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr == `ADCRC_OFS_CTRL && s_axi_wstrb[0];
  assign wr_trig = s_axi_wdata[5:4];

  ////////////////////////////////////////////////////////////////////
  // Shadow of the mode fields, so properties know the current mode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_ff <= 2'h0;
      scan_ff <= 1'b0;
      shot_ff <= 1'b0;
      div_ff <= 3'h0;
    end else if (wr_hs) begin
      trig_ff <= wr_trig;
      scan_ff <= s_axi_wdata[2];
      shot_ff <= s_axi_wdata[3];
      if (s_axi_wstrb[1]) div_ff <= s_axi_wdata[10:8];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////
  property p_wr0_clears;
    wr_hs && !s_axi_wdata[0] && !hw_trig |=> !conv_run_bit_ff;
  endproperty
  a_wr0_clears: assert property (p_wr0_clears) else $error("run kept after write 0");
  property p_sw_set;
    wr_hs && s_axi_wdata[1:0] == 2'h3 && wr_trig == `ADCRC_TRIG_SW &&
      comparator_enable_bit_ff && !conv_run_bit_ff |=> conv_run_bit_ff;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("run not set by write 1");
  property p_wait_refuse;
    wr_hs && s_axi_wdata[0] && wr_trig == `ADCRC_TRIG_WAIT && !conv_run_bit_ff && !hw_trig
      |=> !conv_run_bit_ff;
  endproperty
  a_wait_refuse: assert property (p_wait_refuse) else $error("wait mode took write 1");
  property p_trig_sets;
    trig_ff == `ADCRC_TRIG_WAIT && hw_trig && !conv_run_bit_ff && comparator_enable_bit_ff &&
      !wr_hs |=> conv_run_bit_ff;
  endproperty
  a_trig_sets: assert property (p_trig_sets) else $error("trigger did not set run");
  property p_sel_shot;
    conv_done_ff && shot_ff && !scan_ff && trig_ff != `ADCRC_TRIG_NOWAIT
      |-> ##[0:1] !conv_run_bit_ff;
  endproperty
  a_sel_shot: assert property (p_sel_shot) else $error("one-shot run not cleared");
  property p_scan_hold;
    conv_busy_ff && scan_ff && conv_chan_ff != 2'h3 |-> conv_run_bit_ff;
  endproperty
  a_scan_hold: assert property (p_scan_hold) else $error("scan stopped early");
  property p_nowait_keep;
    conv_done_ff && trig_ff == `ADCRC_TRIG_NOWAIT && !wr_hs |-> conv_run_bit_ff ##1 conv_run_bit_ff;
  endproperty
  a_nowait_keep: assert property (p_nowait_keep) else $error("no-wait run cleared");
  property p_lat_short;
    $rose(conv_run_bit_ff) && trig_ff == `ADCRC_TRIG_SW && div_ff == 3'h7
      |-> !conv_busy_ff ##1 !conv_busy_ff ##1 conv_busy_ff;
  endproperty
  a_lat_short: assert property (p_lat_short) else $error("start latency wrong");
  property p_busy_state;
    conv_busy_ff |-> conv_run_bit_ff && comparator_enable_bit_ff;
  endproperty
  a_busy_state: assert property (p_busy_state) else $error("converting outside run");
endmodule
`default_nettype wire

//--- adcrc_trig_src.sv
// Hardware trigger source model: one-cycle pulses on request.
// Assumes fire is a one-cycle request synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module adcrc_trig_src #(
  parameter MIN_GAP = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  output wire logic hw_trig
);
  logic trig_ff;
  logic pend_ff;
  int gap_ff;

  assign hw_trig = trig_ff;

  ////////////////////////////////////////////////////////////////////
  // Hold a request back until the converter can finish the last run
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_ff <= 1'b0;
      pend_ff <= 1'b0;
      gap_ff <= MIN_GAP;
    end else begin
      trig_ff <= 1'b0;
      if (fire) pend_ff <= 1'b1;
      if (gap_ff < MIN_GAP) gap_ff <= gap_ff + 1;
      if ((pend_ff || fire) && gap_ff >= MIN_GAP) begin
        trig_ff <= 1'b1;
        pend_ff <= 1'b0;
        gap_ff <= 0;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// Testbench for the run control block: plays the CPU on the register
// bus, asks the trigger model for pulses and checks the run bit.
// Assumes the design files and the trigger model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "adcrc_map.vh"

module tb_top;
  localparam int STAB = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, fire = 1'b0;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0] ws = 4'h0;
  logic [1:0] bresp, rresp, chan;
  logic awr, wr, bv, arr, rv, hw_trig, run, cmp, busy, done;
  int err_total = 0, checked = 0, dones = 0, cyc = 0, t0 = 0;
  int lat[8] = '{63, 31, 15, 7, 5, 4, 3, 1};

  adcrc_top #(.STAB_CYC(STAB)) uut (.clk(clk), .rst(rst), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .hw_trig(hw_trig), .conv_run_bit_ff(run), .comparator_enable_bit_ff(cmp),
    .conv_busy_ff(busy), .conv_done_ff(done), .conv_chan_ff(chan));
  adcrc_trig_src #(.MIN_GAP(200)) trig_src (.clk(clk), .rst(rst), .fire(fire),
    .hw_trig(hw_trig));

  always #12.5 clk = ~clk;

  // Count finished conversions and clock edges
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (done === 1'b1) dones <= dones + 1;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Write one word; t0 keeps the edge at which it was taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    aw <= a;
    wd <= d;
    ws <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    @(posedge clk);
    while (awr !== 1'b1) @(posedge clk);
    t0 = cyc;
    awv <= 1'b0;
    wv <= 1'b0;
    @(posedge clk);
    while (bv !== 1'b1) @(posedge clk);
    chk("write resp", {30'h0, bresp}, {30'h0, `ADCRC_RESP_OKAY});
    br <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    @(posedge clk);
    while (arr !== 1'b1) @(posedge clk);
    arv <= 1'b0;
    @(posedge clk);
    while (rv !== 1'b1) @(posedge clk);
    d = rd;
    r = rresp;
    rr <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] mk(logic [1:0] tr, logic sc, logic sh, logic [2:0] dv);
    return {21'h0, dv, 2'h0, tr, sh, sc, 2'h0};
  endfunction

  // Mode set with the comparator off, then comparator on and settled
  task automatic setup(input logic [31:0] m);
    axi_wr(8'h00, m);
    axi_wr(8'h00, m | 32'h2);
    repeat (`ADCRC_SETTLE_CYC) @(posedge clk);
  endtask

  task automatic wait_done(input int n);
    while (dones < n) @(posedge clk);
  endtask

  // Ask for a trigger; return one edge after it was seen
  task automatic trig;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    while (hw_trig !== 1'b1) @(posedge clk);
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(8'h00, d, r);
    chk("ctrl reset", d, `ADCRC_CTRL_RST);
    axi_rd(8'h0C, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, `ADCRC_RESP_DECERR});
    chk("unmapped data", d, 32'h0);
  endtask

  task automatic t_sw_lat;
    for (int i = 0; i < 8; i++) begin
      setup(mk(`ADCRC_TRIG_SW, 1'b0, 1'b1, i[2:0]));
      axi_wr(8'h00, mk(`ADCRC_TRIG_SW, 1'b0, 1'b1, i[2:0]) | 32'h3);
      while (busy !== 1'b1) @(posedge clk);
      chk("start latency", cyc - t0, lat[i] + 2);
      wait_done(dones + 1);
      chk("one-shot run", {31'h0, run}, 32'h0);
    end
  endtask

  task automatic t_sw_scan_seq;
    int n;
    setup(mk(`ADCRC_TRIG_SW, 1'b1, 1'b1, 3'h7));
    n = dones;
    axi_wr(8'h00, mk(`ADCRC_TRIG_SW, 1'b1, 1'b1, 3'h7) | 32'h3);
    while (run !== 1'b0) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("scan conversions", dones - n, 4);
    setup(mk(`ADCRC_TRIG_SW, 1'b0, 1'b0, 3'h7));
    axi_wr(8'h00, mk(`ADCRC_TRIG_SW, 1'b0, 1'b0, 3'h7) | 32'h3);
    wait_done(dones + 2);
    chk("sequential run", {31'h0, run}, 32'h1);
    axi_wr(8'h00, mk(`ADCRC_TRIG_SW, 1'b0, 1'b0, 3'h7) | 32'h2);
    chk("stop run", {31'h0, run}, 32'h0);
    chk("stop busy", {31'h0, busy}, 32'h0);
  endtask

  task automatic t_nowait;
    setup(mk(`ADCRC_TRIG_NOWAIT, 1'b0, 1'b1, 3'h7));
    axi_wr(8'h00, mk(`ADCRC_TRIG_NOWAIT, 1'b0, 1'b1, 3'h7) | 32'h3);
    trig();
    wait_done(dones + 1);
    repeat (4) @(posedge clk);
    chk("no-wait run kept", {31'h0, run}, 32'h1);
    axi_wr(8'h00, mk(`ADCRC_TRIG_NOWAIT, 1'b0, 1'b1, 3'h7) | 32'h2);
    chk("no-wait stop", {31'h0, run}, 32'h0);
  endtask

  task automatic t_wait;
    int n;
    setup(mk(`ADCRC_TRIG_WAIT, 1'b0, 1'b1, 3'h7));
    axi_wr(8'h00, mk(`ADCRC_TRIG_WAIT, 1'b0, 1'b1, 3'h7) | 32'h3);
    chk("wait write one", {31'h0, run}, 32'h0);
    trig();
    chk("trigger sets run", {31'h0, run}, 32'h1);
    wait_done(dones + 1);
    chk("wait one-shot run", {31'h0, run}, 32'h0);
    setup(mk(`ADCRC_TRIG_WAIT, 1'b1, 1'b1, 3'h7));
    n = dones;
    trig();
    t0 = cyc;
    while (run !== 1'b0) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("wait scan count", dones - n, 4);
    chk("scan without restarts", {31'h0, (cyc - t0) <= STAB + 4 * 38 + 16}, 32'h1);
    setup(mk(`ADCRC_TRIG_WAIT, 1'b0, 1'b0, 3'h7));
    trig();
    wait_done(dones + 1);
    axi_wr(8'h00, mk(`ADCRC_TRIG_WAIT, 1'b0, 1'b0, 3'h7) | 32'h2);
    chk("standby run", {31'h0, run}, 32'h0);
    chk("standby comparator", {31'h0, cmp}, 32'h1);
    trig();
    chk("trigger from standby", {31'h0, run}, 32'h1);
    axi_wr(8'h00, mk(`ADCRC_TRIG_WAIT, 1'b0, 1'b0, 3'h7) | 32'h2);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_sw_lat();
    t_sw_scan_seq();
    t_nowait();
    t_wait();
    tally_and_finish();
  end

  // Whole run needs well under 20000 cycles
  initial begin
    #(25 * 20000);
    err_total++;
    tally_and_finish();
  end
endmodule

bind adcrc_top adcrc_top_props #(.CONV_FAD(CONV_FAD), .STAB_CYC(STAB_CYC)) u_props (
  .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .hw_trig(hw_trig), .conv_run_bit_ff(conv_run_bit_ff),
  .comparator_enable_bit_ff(comparator_enable_bit_ff), .conv_busy_ff(conv_busy_ff),
  .conv_done_ff(conv_done_ff), .conv_chan_ff(conv_chan_ff));
`default_nettype wire
